// File: hw/bridge_recirc_current_limit.sv
// Purpose: Bridge PWM recirculation selection and fixed-off-time current limiter.
// Assumes: Commutation controller on aclk gives comm_start and bemf_rising.
// Notes:   Configuration and status over AXI4-Lite; comparators and PWM come from pins.
// Functional notes
// [RULE1] Mode 01: recirculate on high side, slow decay, every off interval.
// [RULE2] Mode 10: recirculate on low side, slow decay, every off interval.
// [RULE3] Mode resets to 00: slow decay, side from expected bemf direction.
// [RULE4] Mixed, falling bemf: low side from commutation, high side after crossing.
// [RULE5] Mixed, rising bemf: high side from commutation, low side after crossing.
// [RULE6] Mode 11: all switches off during off time, fast decay.
// [RULE7] Zero-crossing comparator is digitally filtered before use.
// [RULE8] Degauss enable compensates crossing detection for winding degauss after commutation.
// [RULE9] Each PWM cycle starts by switching the bridge into drive.
// [RULE10] Current above threshold moves bridge to recirculation for fixed off time.
// [RULE11] Indirect and speed modes: off time equals programmed PWM period.
// [RULE12] Direct mode: PWM frequency from input, off time from off_time_code.
// [RULE13] Software should program off time at least the input PWM period.
// [RULE14] Current mode: fixed off time alone sets the PWM frequency.
// [RULE15] Current mode: upper four bits of 8-bit duty replace current_limit_code.
// [RULE16] Current mode: threshold is duty ratio times 200 mV maximum.
// [RULE17] Other modes: threshold from serial four-bit current_limit_code.
// [RULE18] Code n gives (n+1) steps of 12.5 mV, 12.5 to 200 mV.
// [RULE19] Off time is 20 us plus n times 1.6 us.
// [RULE20] Limit comparator blanked blank_time_code times 400 ns after drive turn-on.
// [RULE21] Comparator outputs are synchronised before any state decision.
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
module bridge_recirc_current_limit (
  input  wire  logic        aclk,          // System clock, 100 MHz.
  input  wire  logic        aresetn,       // Synchronous reset, active low.
  input  wire  logic [7:0]  awaddr,        // Write address.
  input  wire  logic        awvalid,       // Write address valid.
  output logic              awready,       // Write address ready.
  input  wire  logic [31:0] wdata,         // Write data.
  input  wire  logic [3:0]  wstrb,         // Write byte strobes.
  input  wire  logic        wvalid,        // Write data valid.
  output logic              wready,        // Write data ready.
  output logic [1:0]        bresp,         // Write response.
  output logic              bvalid,        // Write response valid.
  input  wire  logic        bready,        // Write response ready.
  input  wire  logic [7:0]  araddr,        // Read address.
  input  wire  logic        arvalid,       // Read address valid.
  output logic              arready,       // Read address ready.
  output logic [31:0]       rdata,         // Read data.
  output logic [1:0]        rresp,         // Read response.
  output logic              rvalid,        // Read data valid.
  input  wire  logic        rready,        // Read data ready.
  input  wire  logic        ilim_cmp,      // Current-limit comparator pin.
  input  wire  logic        zc_cmp,        // Zero-crossing comparator pin.
  input  wire  logic        pwm_in,        // PWM control input pin.
  input  wire  logic        comm_start,    // Commutation period start pulse.
  input  wire  logic        bemf_rising,   // Expected bemf direction, 1 rising.
  output logic              bridge_drive,  // Bridge in drive configuration.
  output logic              recirc_hs,     // High-side recirculation on.
  output logic              recirc_ls,     // Low-side recirculation on.
  output logic              zc_detect,     // Filtered zero-crossing pulse.
  output logic [4:0]        thresh_steps   // Threshold in 12.5 mV steps.
);
  import recirc_pkg::*;

  typedef enum logic [1:0] {S_WAIT, S_DRIVE, S_OFF} state_type;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [2:0] pin_raw;
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic       ilim_s;
  logic       pwm_s;

  assign pin_raw = {pwm_in, zc_cmp, ilim_cmp};
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= pin_raw[i]; // [RULE21]
        sync_q[i] <= meta_q[i];
      end
    end
  end
  assign ilim_s = sync_q[0];
  assign pwm_s  = sync_q[2];

  // ************************************************************
  // Filter and duty meter
  // ************************************************************
  sense_if sif ();
  assign sif.zc_s   = sync_q[1];
  assign sif.comm   = comm_start;
  assign sif.rising = bemf_rising;
  assign sif.pwm_s  = pwm_s;

  zc_filter u_filter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sif     (sif.filt)
  );

  duty_meter u_duty (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sif     (sif.meter)
  );

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  recirc_mode_type rm_q;
  ctrl_mode_type   cm_q;
  logic            dgc_q;
  logic [3:0]      clc_q;
  logic [4:0]      otc_q;
  logic [3:0]      btc_q;
  logic            aw_full_q;
  logic            w_full_q;
  logic [7:0]      aw_addr_q;
  logic [31:0]     w_data_q;
  logic [3:0]      w_strb_q;
  logic            aw_hs;
  logic            w_hs;
  logic            do_wr;
  logic            aw_full_d;
  logic            w_full_d;
  logic            rvalid_d;
  logic [31:0]     rd_word;
  logic [1:0]      rd_resp;
  state_type       st_q;
  state_type       st_d;
  logic            mixed_hs_q;
  logic            drive_q;
  logic            hs_q;
  logic            ls_q;
  logic [4:0]      thresh_q;

  assign aw_hs     = awvalid && awready;
  assign w_hs      = wvalid && wready;
  assign do_wr     = aw_full_q && w_full_q && !bvalid;
  assign aw_full_d = (aw_full_q || aw_hs) && !do_wr;
  assign w_full_d  = (w_full_q || w_hs) && !do_wr;
  assign rvalid_d  = (rvalid && !rready) || (arvalid && arready);

  // Address and data are held independently, so either may arrive first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready   <= !aw_full_d;
      wready    <= !w_full_d;
      if (aw_hs) aw_addr_q <= awaddr;
      if (w_hs) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid <= 1'b1;
      bresp  <= (aw_addr_q == CTRL_ADDR || aw_addr_q == LIMIT_ADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rm_q  <= RM_RESET; // [RULE3]
      dgc_q <= DGC_RESET;
      cm_q  <= CM_RESET;
      clc_q <= CLC_RESET;
      otc_q <= OTC_RESET;
      btc_q <= BTC_RESET;
    end else if (do_wr && aw_addr_q == CTRL_ADDR && w_strb_q[0]) begin
      rm_q  <= recirc_mode_type'(w_data_q[F_RM +: 2]);
      dgc_q <= w_data_q[F_DGC];
      cm_q  <= ctrl_mode_type'(w_data_q[F_CM +: 2]);
    end else if (do_wr && aw_addr_q == LIMIT_ADDR) begin
      if (w_strb_q[0]) clc_q <= w_data_q[F_CLC +: 4];
      if (w_strb_q[1]) otc_q <= w_data_q[F_OTC +: 5];
      if (w_strb_q[2]) btc_q <= w_data_q[F_BTC +: 4];
    end
  end
  assign sif.degauss_comp_enable = dgc_q;

  always_comb begin
    rd_word = '0;
    rd_resp = RESP_OKAY;
    unique case (araddr)
      CTRL_ADDR: begin
        rd_word[F_RM +: 2] = rm_q;
        rd_word[F_DGC]     = dgc_q;
        rd_word[F_CM +: 2] = cm_q;
      end
      LIMIT_ADDR: begin
        rd_word[F_CLC +: 4] = clc_q;
        rd_word[F_OTC +: 5] = otc_q;
        rd_word[F_BTC +: 4] = btc_q;
      end
      STATUS_ADDR: rd_word = {8'h00, sif.duty, 3'h0, thresh_q, 2'h0, mixed_hs_q, ls_q, hs_q, drive_q, st_q};
      default: rd_resp = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= !rvalid_d;
      rvalid  <= rvalid_d;
      if (arvalid && arready) begin
        rdata <= rd_word;
        rresp <= rd_resp;
      end
    end
  end

  // ************************************************************
  // Cycle timing
  // ************************************************************
  cnt_type off_cyc;
  cnt_type blank_cyc;
  cnt_type per_q;
  cnt_type off_q;
  cnt_type blank_q;
  logic    pwm_prev_q;
  logic    cyc_start;
  logic    timed;

  assign off_cyc   = cnt_type'(OFF_BASE_CYC) + cnt_type'(OFF_STEP_CYC) * cnt_type'(otc_q); // [RULE19]
  assign blank_cyc = cnt_type'(BLANK_STEP_CYC) * cnt_type'(btc_q); // [RULE20]
  assign timed     = cm_q == CM_INDIRECT || cm_q == CM_SPEED;
  // Indirect and speed modes run a fixed period equal to the off time.
  assign cyc_start = timed ? per_q == off_cyc - cnt_type'(1) : pwm_s && !pwm_prev_q; // [RULE11] [RULE12]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      per_q      <= '0;
      pwm_prev_q <= 1'b0;
    end else begin
      pwm_prev_q <= pwm_s;
      per_q      <= (!timed || cyc_start) ? '0 : per_q + cnt_type'(1);
    end
  end

  // ************************************************************
  // Bridge state machine
  // ************************************************************
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      S_WAIT: if (cyc_start) st_d = S_DRIVE; // [RULE9]
      S_DRIVE: begin
        if (cm_q == CM_DIRECT && !pwm_s) st_d = S_WAIT; // [RULE12]
        else if (blank_q == '0 && ilim_s) st_d = S_OFF; // [RULE10] [RULE20]
      end
      S_OFF: begin
        // In current mode the end of the off time alone restarts drive.
        if (off_q == '0 && (cyc_start || cm_q == CM_CURRENT || (cm_q == CM_DIRECT && pwm_s))) begin
          st_d = S_DRIVE; // [RULE14]
        end else if (off_q == '0) begin
          st_d = S_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q    <= S_WAIT;
      off_q   <= '0;
      blank_q <= '0;
    end else begin
      st_q <= st_d;
      if (st_d == S_OFF && st_q != S_OFF) off_q <= off_cyc - cnt_type'(1); // [RULE10]
      else if (off_q != '0) off_q <= off_q - cnt_type'(1);
      if (st_d == S_DRIVE && st_q != S_DRIVE) blank_q <= blank_cyc; // [RULE20]
      else if (blank_q != '0) blank_q <= blank_q - cnt_type'(1);
    end
  end

  // ************************************************************
  // Recirculation side and outputs
  // ************************************************************
  logic side_hs;
  logic side_ls;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mixed_hs_q <= 1'b0;
    end else if (comm_start) begin
      mixed_hs_q <= bemf_rising; // [RULE4] [RULE5]
    end else if (sif.zc_evt) begin
      mixed_hs_q <= !mixed_hs_q; // [RULE4] [RULE5]
    end
  end

  always_comb begin
    side_hs = 1'b0;
    side_ls = 1'b0;
    unique case (rm_q)
      RM_HIGH: side_hs = 1'b1; // [RULE1]
      RM_LOW:  side_ls = 1'b1; // [RULE2]
      RM_FAST: side_hs = 1'b0; // [RULE6]
      RM_MIXED: begin
        side_hs = mixed_hs_q; // [RULE3]
        side_ls = !mixed_hs_q;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_q   <= 1'b0;
      hs_q      <= 1'b0;
      ls_q      <= 1'b0;
      zc_detect <= 1'b0;
      thresh_q  <= '0;
    end else begin
      drive_q   <= st_d == S_DRIVE;
      hs_q      <= st_d != S_DRIVE && side_hs;
      ls_q      <= st_d != S_DRIVE && side_ls;
      zc_detect <= sif.zc_evt;
      // Code n means n+1 steps of 12.5 mV; 16 steps is the 200 mV maximum.
      if (cm_q == CM_CURRENT) thresh_q <= {1'b0, sif.duty[7:4]} + 5'h01; // [RULE15] [RULE16]
      else thresh_q <= {1'b0, clc_q} + 5'h01; // [RULE17] [RULE18]
    end
  end

  assign bridge_drive = drive_q;
  assign recirc_hs    = hs_q;
  assign recirc_ls    = ls_q;
  assign thresh_steps = thresh_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_high_side: assert property ($past(aresetn) && $past(rm_q) == RM_HIGH && !drive_q |-> hs_q && !ls_q) // [RULE1]
    else $error("high-side recirculation missing");
  a_low_side: assert property ($past(aresetn) && $past(rm_q) == RM_LOW && !drive_q |-> ls_q && !hs_q) // [RULE2]
    else $error("low-side recirculation missing");
  a_mixed_side: assert property ($past(aresetn) && $past(rm_q) == RM_MIXED && !drive_q |-> hs_q == $past(mixed_hs_q)) // [RULE3]
    else $error("mixed recirculation side wrong");
  a_mixed_flip: assert property (sif.zc_evt && !comm_start |=> mixed_hs_q != $past(mixed_hs_q)) // [RULE4]
    else $error("mixed side not swapped after crossing");
  a_fast_off: assert property ($past(aresetn) && $past(rm_q) == RM_FAST |-> !hs_q && !ls_q) // [RULE6]
    else $error("switch on in fast decay");
  a_start_drive: assert property (st_q == S_WAIT && cyc_start |=> drive_q && st_q == S_DRIVE) // [RULE9]
    else $error("cycle start did not drive");
  a_trip_off: assert property (st_q == S_DRIVE && blank_q == '0 && ilim_s && !(cm_q == CM_DIRECT && !pwm_s)
    |=> st_q == S_OFF && off_q == $past(off_cyc) - cnt_type'(1) && !drive_q) // [RULE10]
    else $error("trip did not start off time");
  a_off_hold: assert property (st_q == S_OFF && off_q != '0 |=> st_q == S_OFF) // [RULE19]
    else $error("off time cut short");
  a_blank_mask: assert property (st_q == S_DRIVE && blank_q != '0 && !(cm_q == CM_DIRECT && !pwm_s) |=> st_q == S_DRIVE) // [RULE20]
    else $error("trip during blanking");
  a_current_thr: assert property (cm_q == CM_CURRENT |=> thresh_q == {1'b0, $past(sif.duty[7:4])} + 5'h01) // [RULE15]
    else $error("current-mode threshold wrong");
  a_serial_thr: assert property (cm_q != CM_CURRENT |=> thresh_q == {1'b0, $past(clc_q)} + 5'h01) // [RULE17]
    else $error("serial threshold wrong");

  c_trip: cover property (st_q == S_DRIVE ##1 st_q == S_OFF);
  c_refire: cover property (cm_q == CM_CURRENT && st_q == S_OFF ##1 st_q == S_DRIVE);
  c_zc: cover property (comm_start ##[1:200] zc_detect);

endmodule : bridge_recirc_current_limit

// File: common/recirc_pkg.sv
// Purpose: Shared constants and types for the bridge recirculation and current-limit block.
// Assumes: 100 MHz system clock, AXI4-Lite register access with 32-bit data.
// Notes:   Times are given in ns and turned into clock counts here.
package recirc_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int OFF_BASE_NS   = 20000;
  localparam int OFF_STEP_NS   = 1600;
  localparam int BLANK_STEP_NS = 400;
  // Least times, so each count rounds up.
  localparam int OFF_BASE_CYC   = (OFF_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_STEP_CYC   = (OFF_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_STEP_CYC = (BLANK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ZC_FILT_CYC    = 8;
  localparam int DUTY_CNT_W     = 20;

  // ************************************************************
  // Register map and fields
  // ************************************************************
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] LIMIT_ADDR  = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam int F_RM  = 0;
  localparam int F_DGC = 2;
  localparam int F_CM  = 4;
  localparam int F_CLC = 0;
  localparam int F_OTC = 8;
  localparam int F_BTC = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {RM_MIXED, RM_HIGH, RM_LOW, RM_FAST} recirc_mode_type;
  typedef enum logic [1:0] {CM_DIRECT, CM_INDIRECT, CM_SPEED, CM_CURRENT} ctrl_mode_type;
  typedef logic [15:0] cnt_type;

  localparam recirc_mode_type RM_RESET  = RM_MIXED;
  localparam ctrl_mode_type   CM_RESET  = CM_DIRECT;
  localparam logic            DGC_RESET = 1'b0;
  localparam logic [3:0]      CLC_RESET = 4'hf;
  localparam logic [4:0]      OTC_RESET = 5'h00;
  localparam logic [3:0]      BTC_RESET = 4'h1;

endpackage : recirc_pkg

// File: common/sense_if.sv
// Purpose: Carries synchronised comparator and PWM levels to the filter and duty meter.
// Assumes: All signals live on aclk.
// Notes:   The top drives the inputs of both modports directly.
interface sense_if;
  logic       zc_s;
  logic       comm;
  logic       rising;
  logic       degauss_comp_enable;
  logic       zc_evt;
  logic       pwm_s;
  logic [7:0] duty;
  modport filt  (input zc_s, comm, rising, degauss_comp_enable, output zc_evt);
  modport meter (input pwm_s, output duty);
endinterface : sense_if

// File: hw/zc_filter.sv
// Purpose: Digital filter on the bemf zero-crossing comparator with degauss compensation.
// Assumes: Comparator level already synchronised; one crossing reported per commutation.
// Notes:   With compensation on, the crossing is armed only once the pre-crossing level is seen.
module zc_filter #(
  parameter int FILT_LEN = recirc_pkg::ZC_FILT_CYC
) (
  input wire logic aclk,    // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  sense_if.filt    sif      // Comparator level and commutation events.
);
  import recirc_pkg::*;
  localparam int W = $clog2(FILT_LEN + 1);

  logic [W-1:0] run_q;
  logic         lvl_q;
  logic         rise_q;
  logic         armed_q;
  logic         done_q;
  logic         evt_q;

  // A level change is accepted only after FILT_LEN equal samples.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= '0;
      lvl_q <= 1'b0;
    end else if (sif.zc_s == lvl_q) begin
      run_q <= '0;
    end else if (run_q == W'(FILT_LEN - 1)) begin
      run_q <= '0;
      lvl_q <= sif.zc_s;
    end else begin
      run_q <= run_q + W'(1);
    end
  end

  // The degauss clamp holds the phase at the post-crossing level, so without
  // compensation a long clamp is reported as an early crossing.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rise_q  <= 1'b0;
      armed_q <= 1'b0;
      done_q  <= 1'b1;
      evt_q   <= 1'b0;
    end else if (sif.comm) begin
      rise_q  <= sif.rising;
      armed_q <= !sif.degauss_comp_enable; // [RULE8]
      done_q  <= 1'b0;
      evt_q   <= 1'b0;
    end else begin
      if (!armed_q && lvl_q == !rise_q) begin
        armed_q <= 1'b1; // [RULE8]
      end
      evt_q <= armed_q && !done_q && lvl_q == rise_q; // [RULE7]
      if (armed_q && lvl_q == rise_q) begin
        done_q <= 1'b1;
      end
    end
  end

  assign sif.zc_evt = evt_q;

endmodule : zc_filter

// File: hw/duty_meter.sv
// Purpose: Measures the PWM input duty cycle to 8-bit resolution.
// Assumes: PWM level already synchronised; period shorter than 2**CNT_W cycles.
// Notes:   A restoring divider takes eight cycles after each rising edge.
module duty_meter #(
  parameter int CNT_W = recirc_pkg::DUTY_CNT_W
) (
  input wire logic aclk,    // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  sense_if.meter   sif      // PWM level in, duty out.
);
  import recirc_pkg::*;

  logic             prev_q;
  logic [CNT_W-1:0] per_q;
  logic [CNT_W-1:0] hi_q;
  logic [CNT_W:0]   rem_q;
  logic [CNT_W-1:0] den_q;
  logic [7:0]       quo_q;
  logic [3:0]       step_q;
  logic [7:0]       duty_q;
  logic             rise;
  logic [CNT_W:0]   rem2;
  logic             fit;

  assign rise = sif.pwm_s && !prev_q;
  assign rem2 = {rem_q[CNT_W-1:0], 1'b0};
  assign fit  = rem2 >= {1'b0, den_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
      per_q  <= '0;
      hi_q   <= '0;
    end else begin
      prev_q <= sif.pwm_s;
      if (rise) begin
        per_q <= CNT_W'(1);
        hi_q  <= CNT_W'(1);
      end else begin
        if (~&per_q) per_q <= per_q + CNT_W'(1);
        if (sif.pwm_s && ~&hi_q) hi_q <= hi_q + CNT_W'(1);
      end
    end
  end

  // A stuck input never gives an edge, so a full period counter reports 0 or 100 %.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rem_q  <= '0;
      den_q  <= '0;
      quo_q  <= '0;
      step_q <= '0;
      duty_q <= '0;
    end else if (rise && per_q != '0) begin
      rem_q  <= {1'b0, hi_q};
      den_q  <= per_q;
      quo_q  <= '0;
      step_q <= 4'h8;
    end else if (step_q != 4'h0) begin
      rem_q  <= fit ? rem2 - {1'b0, den_q} : rem2;
      quo_q  <= {quo_q[6:0], fit};
      step_q <= step_q - 4'h1;
      if (step_q == 4'h1) duty_q <= {quo_q[6:0], fit};
    end else if (&per_q) begin
      duty_q <= sif.pwm_s ? 8'hff : 8'h00;
    end
  end

  assign sif.duty = duty_q;

endmodule : duty_meter

// File: verif/bridge_model.sv
// Purpose: Behavioural bridge and current sense comparator.
// Assumes: Winding current ramps only while the bridge drives.
// Notes:   The trip point is a plain cycle count, not a real current.
module bridge_model #(
  parameter int TRIP = 60
) (
  input  wire logic aclk,         // System clock.
  input  wire logic bridge_drive, // Bridge drive state.
  output logic      ilim_cmp      // High above the limit.
);
  timeunit 1ns;
  timeprecision 1ns;
  int cur = 0;
  // Current decays at once off drive, so every cycle starts from zero.
  always_ff @(posedge aclk) begin
    cur <= bridge_drive ? cur + 1 : 0;
  end
  assign ilim_cmp = (cur > TRIP);
endmodule : bridge_model

// File: verif/test_bridge_recirc_current_limit.sv
// Purpose: Self-checking bench for the recirculation and current limiter.
// Assumes: PWM input held high after start, except in the current-mode duty scenario.
// Notes:   Register reads and writes go over AXI4-Lite.
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module test_bridge_recirc_current_limit;
  timeunit 1ns;
  timeprecision 1ns;
  import recirc_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, ilim_cmp, bridge_drive, recirc_hs, recirc_ls, zc_detect;
  logic zc_cmp = 0, pwm_in = 0, comm_start = 0, bemf_rising = 0;
  logic [4:0] thresh_steps;
  logic [31:0] d;
  int error_cnt = 0, samples_checked = 0, cyc = 0, n;
  always #5 aclk = ~aclk;
  bridge_recirc_current_limit bridge_recirc_current_limit_i (.*);
  bridge_model bridge_model_i (.aclk(aclk), .bridge_drive(bridge_drive), .ilim_cmp(ilim_cmp));
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awvalid && awready) begin aw = 1; awvalid <= 0; end
      if (wvalid && wready) begin w = 1; wvalid <= 0; end
    end
    while (!bvalid) @(posedge aclk);
    rs = bresp;
    bready <= 0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] v);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge aclk);
    v = rdata;
    rready <= 0;
  endtask : axr
  // Waits for the end of a drive interval, then checks the side and length of the off interval.
  task automatic run_mode(input logic [5:0] m, input logic hs, input logic ls, input int otc);
    axw(LIMIT_ADDR, 32'h0001000b | (otc << F_OTC), r);
    axw(CTRL_ADDR, {26'h0, m}, r);
    if (m == 6'h00) begin
      @(posedge aclk) comm_start <= 1;
      @(posedge aclk) comm_start <= 0;
    end
    while (!bridge_drive) @(posedge aclk);
    while (bridge_drive) @(posedge aclk);
    `CHK("recirc_hs", hs, recirc_hs)
    `CHK("recirc_ls", ls, recirc_ls)
    n = 0;
    while (!bridge_drive) begin @(posedge aclk); n++; end
    `CHK("off_cycles", OFF_BASE_CYC + otc * OFF_STEP_CYC, n)
  endtask : run_mode
  // A phase clamped at the post-crossing level must not count as a crossing while compensation is on.
  task automatic zc_check(input logic dg);
    axw(CTRL_ADDR, {29'h0, dg, 2'h0}, r);
    zc_cmp <= 1;
    bemf_rising <= 1;
    repeat (20) @(posedge aclk);
    comm_start <= 1;
    @(posedge aclk) comm_start <= 0;
    n = 0;
    repeat (30) @(posedge aclk) n += zc_detect;
    `CHK("zc_early", !dg, n)
    axr(STATUS_ADDR, d);
    `CHK("mixed_side", dg, d[5])
    zc_cmp <= 0;
    repeat (30) @(posedge aclk);
    zc_cmp <= 1;
    n = 0;
    repeat (30) @(posedge aclk) n += zc_detect;
    `CHK("zc_late", dg, n)
  endtask : zc_check
  // A quarter-duty input in current mode gives code 4, so five threshold steps.
  task automatic duty_check();
    axw(CTRL_ADDR, 32'h00000030, r);
    repeat (4) begin
      pwm_in <= 1;
      repeat (64) @(posedge aclk);
      pwm_in <= 0;
      repeat (192) @(posedge aclk);
    end
    `CHK("thresh_duty", 5'h05, thresh_steps)
    pwm_in <= 1;
  endtask : duty_check
  // Indirect mode: a tripped cycle rests one programmed period, then waits for the next period start.
  task automatic period_check();
    axw(LIMIT_ADDR, 32'h0001000b, r);
    axw(CTRL_ADDR, 32'h00000010, r);
    while (!bridge_drive) @(posedge aclk);
    while (bridge_drive) @(posedge aclk);
    while (!bridge_drive) @(posedge aclk);
    n = 0;
    while (bridge_drive) begin @(posedge aclk); n++; end
    while (!bridge_drive) begin @(posedge aclk); n++; end
    `CHK("period", 2 * OFF_BASE_CYC, n)
  endtask : period_check
  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin error_cnt++; end_of_test(); end
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    axr(CTRL_ADDR, d);
    `CHK("ctrl_reset", 32'h0, d)
    `CHK("thresh_reset", 5'h10, thresh_steps)
    axw(8'h0c, 32'h1, r);
    `CHK("bad_addr_resp", RESP_SLVERR, r)
    axr(8'h0c, d);
    `CHK("bad_rd_resp", RESP_SLVERR, rresp)
    axw(LIMIT_ADDR, 32'h0000000b, r);
    repeat (3) @(posedge aclk);
    `CHK("thresh_code11", 5'h0c, thresh_steps)
    bemf_rising <= 1;
    @(posedge aclk) pwm_in <= 1;
    run_mode(6'h01, 1'b1, 1'b0, 1);
    run_mode(6'h02, 1'b0, 1'b1, 0);
    run_mode(6'h03, 1'b0, 1'b0, 0);
    run_mode(6'h31, 1'b1, 1'b0, 1);
    run_mode(6'h00, 1'b1, 1'b0, 2);
    zc_check(1'b0);
    zc_check(1'b1);
    duty_check();
    period_check();
    end_of_test();
  end
endmodule : test_bridge_recirc_current_limit
